// ==== sim/embi_bus_checker.sv ====
/*
 * Checker for embi_bus: phase order, bus direction, strobes and waits.
 * Assumes it is bound to embi_bus and sees only that module's ports.
 */
module embi_bus_checker (
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // Watched pins
    input wire req_done,
    input wire req_onchip,
    input wire [7:0] upper_addr_byte,
    input wire low_addr_data_oe_n,
    input wire addr_latch_en,
    input wire program_read_strobe_n,
    input wire data_write_strobe_n,
    input wire async_wait_n
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    sequence s_start;
        $rose(addr_latch_en);
    endsequence
    sequence s_wait_held;
        !async_wait_n [*4];
    endsequence
    a_ale_two_cycles: assert property (s_start |=> addr_latch_en ##1 !addr_latch_en)
        else $error("latch strobe width wrong");
    a_no_wait_len: assert property (s_start ##0 async_wait_n [*6] |=> req_done)
        else $error("cycle without wait did not end on time");
    a_wait_stretch: assert property (s_wait_held |-> !req_done || req_onchip)
        else $error("cycle ended while wait held low");
    a_ale_drives: assert property (addr_latch_en |-> !low_addr_data_oe_n)
        else $error("low bus not driven during address phase");
    a_read_released: assert property (!program_read_strobe_n |-> low_addr_data_oe_n)
        else $error("low bus driven during code read");
    a_write_drives: assert property (!data_write_strobe_n |-> !low_addr_data_oe_n)
        else $error("low bus not driven during write");
    a_upper_held: assert property (addr_latch_en |=> $stable(upper_addr_byte))
        else $error("upper address moved in address phase");
    a_strobes_idle: assert property (addr_latch_en |-> program_read_strobe_n && data_write_strobe_n)
        else $error("strobe active in address phase");
    a_done_single: assert property (req_done |=> !req_done)
        else $error("done longer than one cycle");
endmodule
bind embi_bus embi_bus_checker chk_u (.*);

// ==== sim/embi_mem_model.sv ====
/*
 * External memory with address latch and an optional slow wait.
 * Assumes data reads use the basic layout, where the read pin is a strobe.
 */
module embi_mem_model (
    input wire ref_clk,
    input wire slow,
    input wire addr_latch_en,
    input wire [7:0] low_addr_data_out,
    output wire [7:0] low_addr_data_in,
    input wire program_read_strobe_n,
    input wire data_read_pin,
    input wire data_write_strobe_n,
    output wire async_wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lat;
    logic [7:0] mem [0:255];
    logic [3:0] hold = 4'h0;
    logic stb_q = 1'b0;
    wire rd = !program_read_strobe_n || !data_read_pin;
    wire stb = rd || !data_write_strobe_n;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = ~i[7:0];
    end
    // Capturing on the clock avoids a race with the bus turning over to write data.
    always @(posedge ref_clk)
    begin
        if (addr_latch_en)
            lat <= low_addr_data_out;
    end
    always @(posedge data_write_strobe_n)
        mem[lat] <= low_addr_data_out;
    // A released bus shows the inverse so a stale byte never passes.
    assign low_addr_data_in = rd ? mem[lat] : ~mem[lat];
    always @(posedge ref_clk)
    begin
        stb_q <= stb;
        if (slow && stb && !stb_q)
            hold <= 4'h5;
        else if (hold != 4'h0)
            hold <= hold - 4'h1;
    end
    assign async_wait_n = (hold == 4'h0);
endmodule

// ==== sim/tb.sv ====
/*
 * Testbench for embi_bus: steering, bus phases, waits and layouts.
 * Assumes the memory model stands on the external pins.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic bus_layout_cfg_lo = 1'b1;
    logic bus_layout_cfg_hi = 1'b1;
    logic code_fetch_select_n = 1'b1;
    logic port_p17_out = 1'b0;
    logic port_p37_out = 1'b1;
    logic req_valid = 1'b0;
    logic req_kind = 1'b0;
    logic req_write = 1'b0;
    logic [17:0] req_addr = 18'h00000;
    logic [7:0] req_wdata = 8'h00;
    logic slow = 1'b0;
    wire req_done, req_onchip, low_addr_data_oe_n, addr_latch_en, program_read_strobe_n;
    wire data_read_pin, data_write_strobe_n, addr_bit_seventeen, async_wait_n;
    wire [7:0] req_rdata, low_addr_data_out, low_addr_data_in, upper_addr_byte;
    logic [17:0] cap, cyc;
    logic onc, ps;
    integer failures = 0;
    integer n_checks = 0;
    embi_bus dut_u (.*);
    embi_mem_model mem_u (.*);
    always #5 ref_clk = ~ref_clk;
    task automatic check(input [17:0] seen, input [17:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task automatic wrap_up;
    begin
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task automatic do_reset(input s);
    begin
        nrst <= 1'b0;
        code_fetch_select_n <= s;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
    end
    endtask
    // Valid is dropped after one edge so a finished request is never taken twice.
    task automatic req(input k, input w, input [17:0] a, input [7:0] d);
    begin
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        ps = 1'b0;
        // Sampling starts at the taking edge, since an on-chip answer pulses right after it.
        for (cyc = 0; cyc < 40; cyc++)
        begin
            @(posedge ref_clk);
            if (cyc == 0)
                req_valid <= 1'b0;
            #1;
            if (addr_latch_en === 1'b1)
                cap = {low_addr_data_out, upper_addr_byte, addr_bit_seventeen, data_read_pin};
            if (program_read_strobe_n === 1'b0)
                ps = 1'b1;
            onc = req_onchip;
            if (req_done === 1'b1)
                break;
        end
        if (cyc == 40)
        begin
            failures = failures + 1;
            wrap_up;
        end
        repeat (2) @(posedge ref_clk);
    end
    endtask
    task automatic t_offchip;
    begin
        do_reset(1'b0);
        req(1'b0, 1'b0, 18'h00100, 8'h00);
        check(onc, 1'b0);
    end
    endtask
    task automatic t_steer;
    begin
        do_reset(1'b1);
        req(1'b0, 1'b0, 18'h00100, 8'h00);
        check(onc, 1'b1);
        req(1'b0, 1'b0, 18'h0a155, 8'h00);
        check(onc, 1'b0);
        check(req_rdata, 8'haa);
        check(cap, {8'h55, 8'ha1, 1'b0, 1'b1});
        check(cyc, 18'h6);
        code_fetch_select_n <= 1'b0;
        req(1'b0, 1'b0, 18'h00100, 8'h00);
        check(onc, 1'b1);
    end
    endtask
    task automatic t_write_read;
    begin
        req(1'b1, 1'b1, 18'h00155, 8'h3c);
        req(1'b1, 1'b0, 18'h00155, 8'h00);
        check(req_rdata, 8'h3c);
    end
    endtask
    task automatic t_wait;
    begin
        slow <= 1'b1;
        req(1'b0, 1'b0, 18'h0a155, 8'h00);
        check(cyc > 18'h8, 1'b1);
        slow <= 1'b0;
    end
    endtask
    task automatic t_layouts;
    begin
        for (int l = 0; l < 4; l++)
        begin
            {bus_layout_cfg_hi, bus_layout_cfg_lo} <= l[1:0];
            req(1'b0, 1'b0, 18'h28155, 8'h00);
            check(cap, {8'h55, 8'h81, l < 2, l[0]});
            check(ps, l != 3);
        end
    end
    endtask
    initial
    begin
        t_offchip;
        t_steer;
        t_write_read;
        t_wait;
        t_layouts;
        wrap_up;
    end
endmodule

// ==== verilog/embi_bus.v ====
/*
 * External memory bus engine: multiplexed low address/data byte, upper
 * address byte, optional address bits 16 and 17, latch strobe, read
 * strobes, asynchronous wait stretching and code-fetch steering.
 * Assumes the core issues one request at a time and waits for done.
 */
`include "embi_consts.vh"

module embi_bus #(
    parameter [17:0] ROM_LAST = `EMBI_ROM_LAST
)
(
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // Configuration
    input wire bus_layout_cfg_lo,
    input wire bus_layout_cfg_hi,
    input wire code_fetch_select_n,
    input wire port_p17_out,
    input wire port_p37_out,
    // Core request port
    input wire req_valid,
    input wire req_kind,
    input wire req_write,
    input wire [17:0] req_addr,
    input wire [7:0] req_wdata,
    output reg req_done,
    output reg req_onchip,
    output reg [7:0] req_rdata,
    // External bus pins
    output reg [7:0] low_addr_data_out,
    input wire [7:0] low_addr_data_in,
    output reg low_addr_data_oe_n,
    output reg [7:0] upper_addr_byte,
    output reg addr_latch_en,
    output reg program_read_strobe_n,
    output reg data_read_pin,
    output reg data_write_strobe_n,
    output reg addr_bit_seventeen,
    input wire async_wait_n
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_DATA = 3'h2;
    localparam [2:0] ST_WAIT = 3'h3;
    localparam [2:0] ST_END = 3'h4;

    reg [2:0] state_r;
    reg [3:0] cnt_r;
    reg wait_s1_r;
    reg wait_s2_r;
    reg strap_r;
    reg strap_done_r;
    reg kind_r;
    reg write_r;
    reg [17:0] addr_r;
    reg [7:0] wdata_r;

    wire [1:0] layout = {bus_layout_cfg_hi, bus_layout_cfg_lo};
    wire rom_hit = strap_r && (req_addr <= ROM_LAST);
    wire a17_used = (layout == `EMBI_LAYOUT_A17) || (layout == `EMBI_LAYOUT_PAGE16);
    wire a16_used = (layout == `EMBI_LAYOUT_A16) || (layout == `EMBI_LAYOUT_PAGE16);
    wire is_read = ~write_r;
    // Basic layout limits program strobes to the low 64 KB; larger ones cover all.
    wire program_read_strobe_n_range = (layout != `EMBI_LAYOUT_BASIC) || (addr_r[17:16] == 2'h0);

    // The strap is caught on the first edge after reset release and then held,
    // so later pin changes have no effect.
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            strap_r <= 1'b0;
            strap_done_r <= 1'b0;
        end
        else if (!strap_done_r)
        begin
            strap_r <= code_fetch_select_n;
            strap_done_r <= 1'b1;
        end
    end

    // An undriven wait pin reads high through the pad pull-up, so no stretch.
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_s1_r <= 1'b1;
            wait_s2_r <= 1'b1;
        end
        else
        begin
            wait_s1_r <= async_wait_n;
            wait_s2_r <= wait_s1_r;
        end
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            kind_r <= 1'b0;
            write_r <= 1'b0;
            addr_r <= 18'h00000;
            wdata_r <= 8'h00;
            req_done <= 1'b0;
            req_onchip <= 1'b0;
            req_rdata <= 8'h00;
            low_addr_data_out <= 8'h00;
            low_addr_data_oe_n <= 1'b1;
            upper_addr_byte <= 8'h00;
            addr_latch_en <= 1'b0;
            program_read_strobe_n <= 1'b1;
            data_read_pin <= 1'b1;
            data_write_strobe_n <= 1'b1;
            addr_bit_seventeen <= 1'b1;
        end
        else
        begin
            req_done <= 1'b0;
            req_onchip <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    low_addr_data_oe_n <= 1'b1;
                    addr_latch_en <= 1'b0;
                    program_read_strobe_n <= 1'b1;
                    data_write_strobe_n <= 1'b1;
                    data_read_pin <= a16_used ? addr_r[16] : port_p37_out;
                    addr_bit_seventeen <= a17_used ? addr_r[17] : port_p17_out;
                    if (req_valid)
                    begin
                        if (req_kind == `EMBI_KIND_CODE && rom_hit)
                        begin
                            req_done <= 1'b1;
                            req_onchip <= 1'b1;
                        end
                        else
                        begin
                            kind_r <= req_kind;
                            write_r <= req_write;
                            addr_r <= req_addr;
                            wdata_r <= req_wdata;
                            low_addr_data_out <= req_addr[7:0];
                            low_addr_data_oe_n <= 1'b0;
                            upper_addr_byte <= req_addr[15:8];
                            addr_latch_en <= 1'b1;
                            if (a16_used)
                                data_read_pin <= req_addr[16];
                            if (a17_used)
                                addr_bit_seventeen <= req_addr[17];
                            cnt_r <= `EMBI_ADDR_CYCLES;
                            state_r <= ST_ADDR;
                        end
                    end
                end
                ST_ADDR:
                begin
                    if (cnt_r > 4'h1)
                        cnt_r <= cnt_r - 4'h1;
                    else
                    begin
                        addr_latch_en <= 1'b0;
                        if (write_r)
                        begin
                            low_addr_data_out <= wdata_r;
                            data_write_strobe_n <= 1'b0;
                        end
                        else
                        begin
                            low_addr_data_oe_n <= 1'b1;
                            if (kind_r == `EMBI_KIND_CODE)
                                program_read_strobe_n <= ~program_read_strobe_n_range;
                            else if (!a16_used)
                                data_read_pin <= 1'b0;
                        end
                        cnt_r <= `EMBI_DATA_CYCLES;
                        state_r <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    if (cnt_r > 4'h1)
                        cnt_r <= cnt_r - 4'h1;
                    else
                        state_r <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    // Stretch while the synchronised wait is low.
                    if (wait_s2_r)
                    begin
                        if (is_read)
                            req_rdata <= low_addr_data_in;
                        req_done <= 1'b1;
                        program_read_strobe_n <= 1'b1;
                        data_write_strobe_n <= 1'b1;
                        if (!a16_used)
                            data_read_pin <= 1'b1;
                        state_r <= ST_END;
                    end
                end
                ST_END:
                begin
                    low_addr_data_oe_n <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

endmodule

// ==== verilog/embi_consts.vh ====
/*
 * Constants for the external memory bus interface: bus layout codes,
 * cycle timing counts and the default on-chip ROM range.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef EMBI_CONSTS_VH
`define EMBI_CONSTS_VH

// Bus layout codes from the two layout configuration bits {hi, lo}.
`define EMBI_LAYOUT_PAGE16 2'h0
`define EMBI_LAYOUT_A17 2'h1
`define EMBI_LAYOUT_A16 2'h2
`define EMBI_LAYOUT_BASIC 2'h3

// Cycles spent in each bus phase at 100 MHz.
`define EMBI_ADDR_CYCLES 4'h2
`define EMBI_DATA_CYCLES 4'h3

// Default last address of on-chip ROM (32 KB).
`define EMBI_ROM_LAST 18'h07fff

// Cycle kinds on the core request port.
`define EMBI_KIND_CODE 1'b0
`define EMBI_KIND_DATA 1'b1

`endif
